// *** system_config.sv ***
// System configuration register with memory-type feature gating
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: bit 18 enables fixed-range DRAM attributes
// R2: bit 19 allows attribute read and write
// R3: bit 19 clear: writes ignored, reads zero
// R4: bit 20 enables lower limit, I/O ranges
// R5: bit 21 enables upper memory limit
// R6: bit 22 forces write-back above 4GB; the code also requires bit 21 and an address below the upper memory limit
// R7: forcing needs default type enable flag
// R8: range register or table overrides forcing
// R9: defined bits are read and write
// R10: software uses privileged register instructions
// R11: reserved bits read zero, writes ignored
module system_config
  import sysconf_pkg::*;
#(
  parameter int FIX_ENTRIES = 88
) (
  input  wire logic                             clk,
  input  wire logic                             reset,
  input  wire logic                             cfg_wr,
  input  wire logic                             cfg_rd,
  input  wire logic [CFG_WIDTH-1:0]             cfg_wdata,
  output logic      [CFG_WIDTH-1:0]             cfg_rdata,
  input  wire logic                             attr_wr,
  input  wire logic                             attr_rd,
  input  wire logic [$clog2(FIX_ENTRIES)-1:0]   attr_idx,
  input  wire logic [FIX_ATTR_W-1:0]            attr_wdata,
  output logic      [FIX_ATTR_W-1:0]            attr_rdata,
  input  wire logic [$clog2(FIX_ENTRIES)-1:0]   lookup_fix_idx,
  input  wire logic                             lookup_fix_hit,
  input  wire logic [ADDR_WIDTH-1:0]            lookup_addr,
  input  wire logic [ADDR_WIDTH-1:0]            upper_top_of_memory_limit,
  input  wire logic                             default_type_enable_flag,
  input  wire logic [2:0]                       default_type,
  input  wire logic                             range_match,
  input  wire logic [2:0]                       range_type,
  output logic                                  read_to_dram_attribute,
  output logic                                  write_to_dram_attribute,
  output logic                                  lower_limit_active,
  output logic                                  io_ranges_active,
  output logic                                  upper_limit_active,
  output logic      [2:0]                       eff_memtype
);
  // ----------------------------------------------------------
  // Local type and helpers
  // ----------------------------------------------------------
  typedef logic [CFG_WIDTH-1:0] cfg_word_t;

  // One control bit of the configuration word
  function automatic logic cfg_bit(input cfg_word_t word,
                                   input int        pos);
    return word[pos];
  endfunction

  // An attribute pair, or zero while its gate is shut
  function automatic logic [FIX_ATTR_W-1:0] gate_attr(input logic                  open,
                                                      input logic [FIX_ATTR_W-1:0] pair);
    return open ? pair : '0;
  endfunction

  // Lower bound inclusive, upper bound exclusive
  function automatic logic in_window(input logic [ADDR_WIDTH-1:0] addr,
                                     input logic [ADDR_WIDTH-1:0] low,
                                     input logic [ADDR_WIDTH-1:0] high);
    return (addr >= low) && (addr < high);
  endfunction

  // ----------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------
  cfg_word_t cfg_ff;
  cfg_word_t wr_masked;
  cfg_word_t nxt_cfg;

  // R11: reserved bits dropped
  assign wr_masked = cfg_wdata & CFG_WRITE_MASK;
  // R9: defined bits writable
  assign nxt_cfg   = cfg_wr ? wr_masked : cfg_ff;

  // Feature enables decoded from the stored word
  wire fixed_range_ext_attr_enable        = cfg_bit(cfg_ff, FIX_EXT_BIT);
  wire fixed_range_ext_attr_access_enable = cfg_bit(cfg_ff, FIX_ACC_BIT);
  wire variable_io_range_enable           = cfg_bit(cfg_ff, VAR_IO_BIT);
  wire upper_top_of_memory_enable         = cfg_bit(cfg_ff, UPPER_TOM_BIT);
  wire above_4g_writeback_default         = cfg_bit(cfg_ff, FORCE_WB_BIT);

  // A read in the same cycle as a write returns the old word
  // R11: reserved bits read zero
  wire [CFG_WIDTH-1:0] nxt_cfg_rdata = cfg_rd ? cfg_ff : '0;

  // ----------------------------------------------------------
  // Fixed-range attribute storage
  // ----------------------------------------------------------
  // The array keeps its contents while access is locked; only visibility changes
  wire [FIX_ATTR_W-1:0] attr_rd_val;
  wire [FIX_ATTR_W-1:0] attr_use_val;

  fixed_attr_store #(
    .ENTRIES (FIX_ENTRIES)
  ) u_store (
    .clk       (clk),
    .reset     (reset),
    .access_en (fixed_range_ext_attr_access_enable),
    .wr_en     (attr_wr),
    .wr_idx    (attr_idx),
    .wr_attr   (attr_wdata),
    .rd_idx    (attr_idx),
    .rd_attr   (attr_rd_val),
    .use_idx   (lookup_fix_idx),
    .use_attr  (attr_use_val)
  );

  // R3: hidden attributes read zero
  wire [FIX_ATTR_W-1:0] nxt_attr_rdata = gate_attr(attr_rd, attr_rd_val);

  // R1: attributes honoured only when enabled
  wire                  use_attrs   = fixed_range_ext_attr_enable & lookup_fix_hit;
  wire [FIX_ATTR_W-1:0] live_attr   = gate_attr(use_attrs, attr_use_val);
  wire                  nxt_rd_dram = live_attr[ATTR_RD_BIT];
  wire                  nxt_wr_dram = live_attr[ATTR_WR_BIT];

  // ----------------------------------------------------------
  // Limit and range enables
  // ----------------------------------------------------------
  // Both lower gates follow the same control bit
  // R4: lower limit and ranges
  wire nxt_lower_limit = variable_io_range_enable;
  wire nxt_io_ranges   = variable_io_range_enable;
  // R5: upper limit gate
  wire nxt_upper_limit = upper_top_of_memory_enable;

  // ----------------------------------------------------------
  // Memory type selection
  // ----------------------------------------------------------
  // Forcing also needs the upper limit enabled, since the window ends there
  // R6: above 4GB window
  wire in_upper_window = in_window(lookup_addr, FOUR_GB, upper_top_of_memory_limit)
                         & upper_top_of_memory_enable;
  // R7: needs default enable
  wire force_wb        = above_4g_writeback_default & default_type_enable_flag & in_upper_window;

  // Priority, highest first: range match, forced write-back, default type
  memtype_t default_sel;
  memtype_t nxt_memtype;

  assign default_sel = force_wb ? MEMTYPE_WB : default_type;
  // R8: range match overrides
  assign nxt_memtype = range_match ? range_type : default_sel;

  // ----------------------------------------------------------
  // Stored configuration
  // ----------------------------------------------------------
  // Only the defined control bits can ever be set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_ff <= CFG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------------------------
  // Read returns
  // ----------------------------------------------------------
  // Each return stands for one cycle, then falls back to zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_rdata  <= '0;
      attr_rdata <= '0;
    end else begin
      cfg_rdata  <= nxt_cfg_rdata;
      attr_rdata <= nxt_attr_rdata;
    end
  end

  // ----------------------------------------------------------
  // Attribute outputs
  // ----------------------------------------------------------
  // Shown one cycle after the fixed-range hit that selects them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_to_dram_attribute  <= 1'b0;
      write_to_dram_attribute <= 1'b0;
    end else begin
      read_to_dram_attribute  <= nxt_rd_dram;
      write_to_dram_attribute <= nxt_wr_dram;
    end
  end

  // ----------------------------------------------------------
  // Limit gates
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lower_limit_active <= 1'b0;
      io_ranges_active   <= 1'b0;
      upper_limit_active <= 1'b0;
    end else begin
      lower_limit_active <= nxt_lower_limit;
      io_ranges_active   <= nxt_io_ranges;
      upper_limit_active <= nxt_upper_limit;
    end
  end

  // ----------------------------------------------------------
  // Effective memory type
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      eff_memtype <= '0;
    end else begin
      eff_memtype <= nxt_memtype;
    end
  end
endmodule
`default_nettype wire

// *** sysconf_pkg.sv ***
// Package: register layout and memory-type codes for the system configuration block
package sysconf_pkg;
  localparam int          CFG_WIDTH      = 32;
  localparam int          FIX_EXT_BIT    = 18;
  localparam int          FIX_ACC_BIT    = 19;
  localparam int          VAR_IO_BIT     = 20;
  localparam int          UPPER_TOM_BIT  = 21;
  localparam int          FORCE_WB_BIT   = 22;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h007c_0000;
  localparam int          ADDR_WIDTH     = 52;
  localparam logic [51:0] FOUR_GB        = 52'h0_0001_0000_0000;
  localparam logic [2:0]  MEMTYPE_WB     = 3'h6;
  localparam int          FIX_ATTR_W     = 2;
  localparam int          ATTR_RD_BIT    = 1;
  localparam int          ATTR_WR_BIT    = 0;
  typedef logic [2:0] memtype_t;
endpackage

// *** fixed_attr_store.sv ***
// Extended read/write-to-DRAM attribute storage for the fixed-range type registers
`timescale 1ns/1ns
`default_nettype none
module fixed_attr_store
  import sysconf_pkg::*;
#(
  parameter int ENTRIES = 88
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          access_en,
  input  wire logic                          wr_en,
  input  wire logic [$clog2(ENTRIES)-1:0]    wr_idx,
  input  wire logic [FIX_ATTR_W-1:0]         wr_attr,
  input  wire logic [$clog2(ENTRIES)-1:0]    rd_idx,
  output logic      [FIX_ATTR_W-1:0]         rd_attr,
  input  wire logic [$clog2(ENTRIES)-1:0]    use_idx,
  output logic      [FIX_ATTR_W-1:0]         use_attr
);
  logic [FIX_ATTR_W-1:0] attr_ff [ENTRIES];
  wire                   do_write;

  // R3: gated write
  assign do_write = wr_en & access_en;
  // R3: masked read
  assign rd_attr  = access_en ? attr_ff[rd_idx] : '0;
  assign use_attr = attr_ff[use_idx];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ENTRIES; i++) begin
        attr_ff[i] <= '0;
      end
    end else if (do_write) begin
      // R2: software update
      attr_ff[wr_idx] <= wr_attr;
    end
  end
endmodule
`default_nettype wire

// *** system_config_monitor.sv ***
// Checker for the system configuration block
`timescale 1ns/1ns
`default_nettype none
module system_config_monitor
  import sysconf_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic        attr_rd,
  input wire logic        range_match,
  input wire logic        default_type_enable_flag,
  input wire logic        lower_limit_active,
  input wire logic        upper_limit_active,
  input wire logic        read_to_dram_attribute,
  input wire logic        write_to_dram_attribute,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic [1:0]  attr_rdata,
  input wire logic [2:0]  default_type,
  input wire logic [2:0]  range_type,
  input wire logic [2:0]  eff_memtype
);
  logic [31:0] cfg_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_ff <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_ff <= cfg_wdata & CFG_WRITE_MASK;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_read_back: assert property (cfg_rd |=> cfg_rdata == $past(cfg_ff)) else $error("bad rdata");
  a_reserved_zero: assert property ((cfg_rdata & ~CFG_WRITE_MASK) == '0) else $error("reserved");
  a_lower_gate: assert property (lower_limit_active == $past(cfg_ff[VAR_IO_BIT])) else $error("lower");
  a_upper_gate: assert property (upper_limit_active == $past(cfg_ff[UPPER_TOM_BIT])) else $error("upper");
  a_range_wins: assert property (range_match |=> eff_memtype == $past(range_type)) else $error("override");
  a_flag_off:
    assert property (!default_type_enable_flag && !range_match |=> eff_memtype == $past(default_type))
      else $error("flag off");
  a_attr_locked: assert property (attr_rd && !cfg_ff[FIX_ACC_BIT] |=> attr_rdata == 2'h0) else $error("attr");
  a_dram_gate:
    assert property (!cfg_ff[FIX_EXT_BIT] |=> !read_to_dram_attribute && !write_to_dram_attribute)
      else $error("dram");
  c_wb: cover property (eff_memtype == MEMTYPE_WB);
  c_dram: cover property (read_to_dram_attribute);
  c_attr: cover property (attr_rd ##1 attr_rdata != 2'h0);
endmodule
bind system_config system_config_monitor mon (
  .clk                      (clk),
  .reset                    (reset),
  .cfg_wr                   (cfg_wr),
  .cfg_rd                   (cfg_rd),
  .attr_rd                  (attr_rd),
  .range_match              (range_match),
  .default_type_enable_flag (default_type_enable_flag),
  .lower_limit_active       (lower_limit_active),
  .upper_limit_active       (upper_limit_active),
  .read_to_dram_attribute   (read_to_dram_attribute),
  .write_to_dram_attribute  (write_to_dram_attribute),
  .cfg_wdata                (cfg_wdata),
  .cfg_rdata                (cfg_rdata),
  .attr_rdata               (attr_rdata),
  .default_type             (default_type),
  .range_type               (range_type),
  .eff_memtype              (eff_memtype)
);
`default_nettype wire

// *** system_config_tb_top.sv ***
// Self-checking testbench for the system configuration block
`timescale 1ns/1ns
`default_nettype none
module system_config_tb_top import sysconf_pkg::*; ;
  typedef struct packed {logic [4:0] c; logic f, m; logic [1:0] a; logic [2:0] e;} row_t;
  row_t r [7] = '{'{5'h18, 1'h1, 1'h0, 2'h0, 3'h6}, '{5'h18, 1'h1, 1'h0, 2'h1, 3'h2},
    '{5'h18, 1'h1, 1'h0, 2'h2, 3'h2}, '{5'h18, 1'h0, 1'h0, 2'h0, 3'h2}, '{5'h08, 1'h1, 1'h0, 2'h0, 3'h2},
    '{5'h18, 1'h1, 1'h1, 2'h0, 3'h5}, '{5'h14, 1'h1, 1'h0, 2'h0, 3'h2}};
  logic clk = 0, reset = 1, cfg_wr = 0, cfg_rd = 0, attr_wr = 0, attr_rd = 0, lookup_fix_hit = 0;
  logic default_type_enable_flag = 0, range_match = 0, read_to_dram_attribute, write_to_dram_attribute;
  logic lower_limit_active, io_ranges_active, upper_limit_active;
  logic [31:0] cfg_wdata = '0, cfg_rdata;
  logic [6:0] attr_idx = 7'h3, lookup_fix_idx = 7'h3;
  logic [1:0] attr_wdata = '0, attr_rdata, attr_q;
  logic [51:0] lookup_addr = '0, upper_top_of_memory_limit = 52'h2_0000_0000;
  logic [2:0] default_type = 3'h2, range_type = 3'h5, eff_memtype;
  int miscompares = 0, samples_checked = 0;
  system_config dut (.*);
  always #5 clk = ~clk;
  task check(input string what, input logic [51:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task cfg_write(input logic [31:0] v);
    cfg_wr = 1;
    cfg_wdata = v;
    @(negedge clk);
    cfg_wr = 0;
  endtask
  task cfg_read();
    cfg_rd = 1;
    @(negedge clk);
    cfg_rd = 0;
  endtask
  task attr(input logic w, input logic [1:0] d, output logic [1:0] q);
    attr_wr = w;
    attr_rd = !w;
    attr_wdata = d;
    @(negedge clk);
    q = attr_rdata;
    attr_wr = 0;
    attr_rd = 0;
    @(negedge clk);
  endtask
  task give_verdict();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #5000;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (8) @(negedge clk);
    reset = 0;
    check("reset", {lower_limit_active, upper_limit_active, eff_memtype}, 52'h0);
    cfg_write(32'hffff_ffff);
    cfg_read();
    check("reserved", cfg_rdata, CFG_WRITE_MASK);
    foreach (r[i]) begin
      cfg_write({9'h0, r[i].c, 18'h0});
      default_type_enable_flag = r[i].f;
      range_match = r[i].m;
      lookup_addr = r[i].a == 2'h0 ? FOUR_GB : r[i].a == 2'h1 ? FOUR_GB - 52'h1 : upper_top_of_memory_limit;
      @(negedge clk);
      cfg_read();
      check("cfg", cfg_rdata, {9'h0, r[i].c, 18'h0});
      check("type", eff_memtype, r[i].e);
      check("lower", {lower_limit_active, io_ranges_active}, {2{r[i].c[2]}});
      check("upper", upper_limit_active, r[i].c[3]);
    end
    cfg_write(32'h0);
    attr(1'h1, 2'h3, attr_q);
    attr(1'h0, 2'h0, attr_q);
    check("locked", attr_q, 2'h0);
    cfg_write(32'h0008_0000);
    attr(1'h0, 2'h0, attr_q);
    check("dropped", attr_q, 2'h0);
    attr(1'h1, 2'h2, attr_q);
    attr(1'h0, 2'h0, attr_q);
    check("attr", attr_q, 2'h2);
    lookup_fix_hit = 1;
    @(negedge clk);
    check("dram off", {read_to_dram_attribute, write_to_dram_attribute}, 2'h0);
    cfg_write(32'h000c_0000);
    @(negedge clk);
    check("dram on", {read_to_dram_attribute, write_to_dram_attribute}, 2'h2);
    cfg_write(32'h0004_0000);
    attr(1'h0, 2'h0, attr_q);
    check("hidden", attr_q, 2'h0);
    reset = 1;
    @(negedge clk);
    check("in reset", {read_to_dram_attribute, upper_limit_active, eff_memtype}, 52'h0);
    reset = 0;
    cfg_write(32'h0008_0000);
    attr(1'h0, 2'h0, attr_q);
    check("cleared", attr_q, 2'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
